// [include/bitop_call_pkg.sv]
// Package with opcode patterns, field positions and shared carrier types.
`default_nettype none
package bitop_call_pkg;
    localparam int INSTR_W = 14;
    localparam int PC_W = 13;
    localparam int REG_ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int BIT_POS_W = 3;
    localparam int CALL_K_W = 11;
    // Opcode prefixes.
    localparam logic [3:0] OP_BIT_SET = 4'h5;
    localparam logic [3:0] OP_BIT_TEST_SET = 4'h7;
    localparam logic [6:0] OP_REG_CLEAR = 7'h03;
    localparam logic [2:0] OP_CALL = 3'h4;
    // Field positions.
    localparam int BIT_POS_LSB = 7;
    localparam int PAGE_LSB = 3;
    localparam int PC_PAGE_LSB = 11;
    // Counter reset value and register clear value.
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [DATA_W-1:0] CLEAR_VALUE = 8'h00;

    typedef enum logic [2:0]
    {
        ST_EXEC = 3'b001,
        ST_FLUSH_SKIP = 3'b010,
        ST_FLUSH_CALL = 3'b100
    } exec_state_t;

    typedef struct packed
    {
        logic we;
        logic [REG_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } reg_write_t;

    typedef struct packed
    {
        logic push;
        logic [PC_W-1:0] data;
    } stack_push_t;
endpackage
`default_nettype wire

// [rtl/bitop_decode.sv]
// Instruction field decoder for the bit, clear and call instructions.
`default_nettype none
module bitop_decode
(
    // Instruction word.
    input wire logic [bitop_call_pkg::INSTR_W-1:0] instr_i,
    // Decoded classes and fields.
    output logic is_bit_set_o,
    output logic is_bit_test_o,
    output logic is_clear_o,
    output logic is_call_o,
    output logic [bitop_call_pkg::BIT_POS_W-1:0] bit_pos_o,
    output logic [bitop_call_pkg::REG_ADDR_W-1:0] reg_addr_o,
    output logic [bitop_call_pkg::CALL_K_W-1:0] call_k_o
);
    import bitop_call_pkg::*;

    always_comb
    begin
        is_bit_set_o = (instr_i[13:10] == OP_BIT_SET);
        is_bit_test_o = (instr_i[13:10] == OP_BIT_TEST_SET);
        is_clear_o = (instr_i[13:7] == OP_REG_CLEAR);
        is_call_o = (instr_i[13:11] == OP_CALL);
        bit_pos_o = instr_i[BIT_POS_LSB +: BIT_POS_W];
        reg_addr_o = instr_i[REG_ADDR_W-1:0];
        call_k_o = instr_i[CALL_K_W-1:0];
    end
endmodule
`default_nettype wire

// [rtl/bitop_call_exec.sv]
// Execute stage for bit set, bit test skip, register clear and call.
// Functional notes
// - Bit test skips the next instruction when the tested bit is one.
// - A taken skip replaces the prefetched word with a no-op cycle.
// - Register clear writes zero, sets the zero flag, takes one cycle.
// - Call pushes the address after the call on the same clock edge that loads the counter.
// - Call loads its eleven-bit target into counter bits ten to zero.
// - Call takes counter bits twelve and eleven from page latch bits 4:3.
// - Call takes two cycles, flushing the prefetched word.
`default_nettype none
module bitop_call_exec
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic srst_i,
    // Instruction in execute and its register operand.
    input wire logic instr_valid_i,
    input wire logic [bitop_call_pkg::INSTR_W-1:0] instr_i,
    input wire logic [bitop_call_pkg::DATA_W-1:0] reg_rdata_i,
    input wire logic [bitop_call_pkg::DATA_W-1:0] page_latch_i,
    // Register file, flag, stack and counter outputs.
    output bitop_call_pkg::reg_write_t reg_wr_o,
    output logic zero_set_o,
    output bitop_call_pkg::stack_push_t stack_o,
    output logic [bitop_call_pkg::PC_W-1:0] pc_o,
    output logic flush_o,
    output logic busy_o
);
    import bitop_call_pkg::*;

    logic is_set, is_test, is_clr, is_call;
    logic [BIT_POS_W-1:0] bit_pos;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [CALL_K_W-1:0] call_k;
    logic exec;
    logic skip;
    logic [DATA_W-1:0] set_mask;
    exec_state_t state_q;

    bitop_decode u_dec
    (
        .instr_i(instr_i),
        .is_bit_set_o(is_set),
        .is_bit_test_o(is_test),
        .is_clear_o(is_clr),
        .is_call_o(is_call),
        .bit_pos_o(bit_pos),
        .reg_addr_o(reg_addr),
        .call_k_o(call_k)
    );

    always_comb
    begin
        exec = instr_valid_i && (state_q == ST_EXEC);
        skip = exec && is_test && reg_rdata_i[bit_pos];
        set_mask = DATA_W'(1) << bit_pos;
    end

    //**********************************************************
    // Sequencing of flush cycles.
    //**********************************************************
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_q <= ST_EXEC;
        end
        else
        begin
            case (state_q)
                ST_EXEC:
                begin
                    if (skip)
                        state_q <= ST_FLUSH_SKIP;
                    else if (exec && is_call)
                        state_q <= ST_FLUSH_CALL;
                end
                default:
                    state_q <= ST_EXEC;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            flush_o <= 1'b0;
            busy_o <= 1'b0;
        end
        else
        begin
            flush_o <= skip || (exec && is_call);
            busy_o <= skip || (exec && is_call);
        end
    end

    //**********************************************************
    // Register writes and zero flag.
    //**********************************************************
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            reg_wr_o <= '0;
            zero_set_o <= 1'b0;
        end
        else
        begin
            reg_wr_o.we <= exec && (is_set || is_clr);
            reg_wr_o.addr <= reg_addr;
            if (is_clr)
                reg_wr_o.data <= CLEAR_VALUE;
            else
                reg_wr_o.data <= reg_rdata_i | set_mask;
            zero_set_o <= exec && is_clr;
        end
    end

    //**********************************************************
    // Program counter and return stack.
    //**********************************************************
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            pc_o <= PC_RESET;
            stack_o <= '0;
        end
        else
        begin
            stack_o.push <= exec && is_call;
            if (exec && is_call)
            begin
                stack_o.data <= pc_o + PC_W'(1);
                pc_o <= {page_latch_i[PAGE_LSB +: 2],
                    call_k};
            end
            else if (exec || state_q != ST_EXEC)
                pc_o <= pc_o + PC_W'(1);
        end
    end

    //**********************************************************
    // Checks.
    //**********************************************************
    bit_set_write_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        exec && is_set |=> reg_wr_o.we && !zero_set_o
        && reg_wr_o.data == ($past(reg_rdata_i) | $past(set_mask)))
        else $error("bit set write wrong");
    skip_taken_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        skip |=> flush_o && state_q == ST_FLUSH_SKIP)
        else $error("skip not taken");
    skip_nop_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        skip |=> !reg_wr_o.we ##1 (!reg_wr_o.we && state_q == ST_EXEC))
        else $error("skip slot not two cycles");
    clear_zero_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        exec && is_clr |=> zero_set_o && reg_wr_o.we
        && reg_wr_o.data == CLEAR_VALUE)
        else $error("clear did not zero");
    call_push_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        exec && is_call |=> stack_o.push
        && stack_o.data == $past(pc_o) + PC_W'(1))
        else $error("call push wrong");
    call_low_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        exec && is_call |=> pc_o[10:0] == $past(call_k))
        else $error("call target wrong");
    call_page_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        exec && is_call |=> pc_o[12:11] == $past(page_latch_i[4:3])
        && !zero_set_o)
        else $error("call page wrong");
    call_two_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        exec && is_call |=> busy_o && state_q == ST_FLUSH_CALL
        ##1 state_q == ST_EXEC)
        else $error("call not two cycles");
    decode_field_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        exec && (is_set || is_clr) |=> reg_wr_o.addr == $past(instr_i[6:0]))
        else $error("address field wrong");
    decode_excl_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        $onehot0({is_set, is_test, is_clr, is_call}))
        else $error("decode overlap");

    //**********************************************************
    // Slot and counter checks.
    //**********************************************************
    test_no_write_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        exec && is_test |=> !reg_wr_o.we && !zero_set_o && !stack_o.push)
        else $error("bit test wrote");
    test_clear_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        exec && is_test && !reg_rdata_i[bit_pos] |=> !flush_o && !busy_o)
        else $error("skip taken on clear bit");
    slot_quiet_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        state_q != ST_EXEC |=> !reg_wr_o.we && !zero_set_o
        && !stack_o.push && !flush_o)
        else $error("slot word executed");
    slot_single_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        busy_o |=> !busy_o)
        else $error("slot longer than one cycle");
    one_cycle_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        exec && (is_set || is_clr) |=> !busy_o && state_q == ST_EXEC)
        else $error("set or clear took two cycles");
    pc_advance_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        (exec && !is_call) || state_q != ST_EXEC
        |=> pc_o == $past(pc_o) + PC_W'(1))
        else $error("counter did not advance");
endmodule
`default_nettype wire

// [tb/reg_file_model.sv]
// Data register file model that answers the execute stage.
`default_nettype none
module reg_file_model
(
    // Clock.
    input wire logic clk_i,
    // Read address and write request.
    input wire logic [bitop_call_pkg::REG_ADDR_W-1:0] addr_i,
    input wire bitop_call_pkg::reg_write_t wr_i,
    // Read data.
    output logic [bitop_call_pkg::DATA_W-1:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import bitop_call_pkg::*;
    logic [DATA_W-1:0] mem [128];
    assign rdata_o = mem[addr_i];
    always @(posedge clk_i)
    begin
        if (wr_i.we)
            mem[wr_i.addr] <= wr_i.data;
    end
    initial
    begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i * 37);
    end
endmodule
`default_nettype wire

// [tb/bitop_call_exec_tb.sv]
// Self-checking bench for the bit, clear and call execute stage.
`default_nettype none
module bitop_call_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bitop_call_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic instr_valid_i = 1'b0;
    logic [INSTR_W-1:0] instr_i = '0;
    logic [DATA_W-1:0] page_latch_i = '0;
    logic [DATA_W-1:0] reg_rdata;
    reg_write_t reg_wr;
    stack_push_t stack;
    logic [PC_W-1:0] pc;
    logic zero_set, flush, busy;
    int fail_count = 0;
    int checks = 0;
    always #4 clk_i = ~clk_i;
    bitop_call_exec dut (.clk_i(clk_i), .srst_i(srst_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .reg_rdata_i(reg_rdata), .page_latch_i(page_latch_i),
        .reg_wr_o(reg_wr), .zero_set_o(zero_set), .stack_o(stack),
        .pc_o(pc), .flush_o(flush), .busy_o(busy));
    reg_file_model regs (.clk_i(clk_i), .addr_i(instr_i[6:0]),
        .wr_i(reg_wr), .rdata_o(reg_rdata));
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Presents one word, checks its answer and any no-op slot after it.
    task automatic run(logic [INSTR_W-1:0] ins);
        logic [DATA_W-1:0] cur;
        logic [PC_W-1:0] pc0;
        logic [2:0] b;
        logic set, tst, clr, cal, fl;
        logic [PC_W-1:0] nxt;
        @(posedge clk_i);
        #1;
        instr_i = ins;
        instr_valid_i = 1'b1;
        page_latch_i = 8'($urandom);
        cur = regs.mem[ins[6:0]];
        pc0 = pc;
        b = ins[9:7];
        set = ins[13:10] == 4'b0101;
        tst = ins[13:10] == 4'b0111;
        clr = ins[13:7] == 7'b0000011;
        cal = ins[13:11] == 3'b100;
        fl = (tst & cur[b]) | cal;
        nxt = cal ? 13'({page_latch_i[4:3], ins[10:0]} + 13'h1)
            : 13'(pc0 + 13'h2);
        @(posedge clk_i);
        #1;
        instr_valid_i = fl;
        instr_i = 14'h1780 | 14'(ins[6:0]);
        chk("write enable", set | clr, reg_wr.we);
        if (set | clr)
        begin
            chk("write addr", ins[6:0], reg_wr.addr);
            chk("write data", set ? (cur | (8'h01 << b)) : 8'h00,
                reg_wr.data);
        end
        chk("zero flag", clr, zero_set);
        chk("flush", fl, flush);
        chk("busy", fl, busy);
        chk("push", cal, stack.push);
        if (cal)
        begin
            chk("return addr", 13'(pc0 + 13'h1), stack.data);
            chk("call pc", {page_latch_i[4:3], ins[10:0]},
                pc);
        end
        else
            chk("next pc", 13'(pc0 + 13'h1), pc);
        if (fl)
        begin
            @(posedge clk_i);
            #1;
            instr_valid_i = 1'b0;
            chk("slot write", 0, reg_wr.we);
            chk("slot busy", 0, busy);
            chk("slot push", 0, stack.push);
            chk("slot pc", nxt, pc);
        end
    endtask
    initial
    begin
        void'($urandom(32'ha9c4));
        repeat (3) @(posedge clk_i);
        #1;
        srst_i = 1'b0;
        chk("reset pc", 0, pc);
        run(14'h17ff);
        run(14'h1400);
        run(14'h1c00);
        run(14'h0180);
        run(14'h1c00);
        run(14'h27ff);
        run(14'h2000);
        $display("corner cases done");
        repeat (200)
        begin
            case ($urandom % 5)
                0: run(14'h1400 | 14'($urandom % 1024));
                1: run(14'h1c00 | 14'($urandom % 1024));
                2: run(14'h0180 | 14'($urandom % 128));
                3: run(14'h2000 | 14'($urandom % 2048));
                default: run(14'h0500 | 14'($urandom % 256));
            endcase
        end
        $display("random run done");
        stop_test();
    end
    initial
    begin
        #(8 * 3000);
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
